// ===== verilog/cct_cfg.svh
// Constants for the core cycle timing and compatibility register block.
`ifndef CCT_CFG_SVH
`define CCT_CFG_SVH
// Clocks per machine cycle and per timer increment.
`define CCT_MC_CLKS        4
`define CCT_TMR_SLOW_CLKS  12
`define CCT_TMR_FAST_CLKS  4
// Machine cycles per instruction class.
`define CCT_CYC_ONE        1
`define CCT_CYC_TWO        2
`define CCT_CYC_XRD        2
`define CCT_CYC_MOVDD      3
`define CCT_CYC_INCDP      1
`define CCT_CYC_LONG4      4
`define CCT_CYC_LONG5      5
// Register addresses.
`define CCT_ADR_P5CTL      8'ha2
`define CCT_ADR_CANOP      8'ha7
`define CCT_ADR_XIEN       8'he8
`define CCT_ADR_XIPR       8'hf8
`define CCT_ADR_CAN_LO     8'ha3
`define CCT_ADR_CAN_HI     8'ha6
// Bit positions.
`define CCT_B_PIN_IO       3
`define CCT_B_BASE         6
`define CCT_B_PRE6         3
`define CCT_B_PRE7         4
`define CCT_B_IRQ          6
// Reset and fixed read values.
`define CCT_RST_REG        8'h00
`define CCT_ONES           8'hff
`define CCT_UNMAPPED       8'h00
`endif

// ===== verilog/cct_pkg.sv
// Types for the core cycle timing and compatibility register block.
`default_nettype none
package cct_pkg;
   // Instruction timing classes, one-hot.
   typedef enum logic [6:0] {
      cct_i_one   = 7'h01,
      cct_i_two   = 7'h02,
      cct_i_xrd   = 7'h04,
      cct_i_movdd = 7'h08,
      cct_i_incdp = 7'h10,
      cct_i_long4 = 7'h20,
      cct_i_long5 = 7'h40
   } cct_instr_e;
   // Execution sequencer states, one-hot.
   typedef enum logic [1:0] {
      cct_idle = 2'b01,
      cct_run  = 2'b10
   } cct_exec_e;
endpackage
`default_nettype wire

// ===== verilog/cct_core_timing.sv
// Machine-cycle timing, timer prescale and compatibility registers of the core.
// Operation
// - Each machine cycle lasts exactly four oscillator clocks.
// - One address latch enable pulse is produced every machine cycle.
// - After reset timers advance once every twelve oscillator clocks.
// - With fast rate selected timers advance once every four clocks.
// - External data read by data pointer completes in two machine cycles.
// - Direct-to-direct move takes three machine cycles, twelve clocks.
// - Data pointer increment takes one machine cycle.
// - Most instructions take one or two cycles, longest four or five.
// - Instruction status effects match the standard instruction set exactly.
// - Added registers sit at addresses apart from all legacy registers.
// - The core provides 256 bytes of internal scratchpad RAM.
// - Without CAN, the other CAN-related bits are read-only and read as one.
// - Pin select bit in port 5 control stays plain read/write storage.
// - Upper prescale, CAN irq enable and priority bits are plain storage.
// - Base-address select bit in port 5 control keeps its function.
`include "cct_cfg.svh"
`default_nettype none
module cct_core_timing
   import cct_pkg::*;
#(
   parameter int RAM_DEPTH = 256,
   parameter int RAM_AW    = 8
) (
   input  wire logic        clock,                 // Oscillator clock.
   input  wire logic        resetn,                // Asynchronous reset, active low.
   input  wire logic        clk_en,                // Freezes all state while low.
   input  wire logic        fast_timer_sel,        // Selects four clocks per timer tick.
   input  wire logic        instr_start,           // Request to run one instruction.
   input  wire cct_instr_e  instr_class,           // Timing class of the request.
   output logic             instr_accept,          // Request taken this cycle.
   output logic             instr_busy,            // Instruction in progress.
   output logic             instr_done,            // Last clock of the instruction.
   output logic [1:0]       mc_phase,              // Clock within the machine cycle.
   output logic             ale,                   // Address latch enable.
   output logic             timer_tick,            // Timer increment strobe.
   input  wire logic [7:0]  sfr_addr,              // Register address.
   input  wire logic        sfr_wr,                // Register write strobe.
   input  wire logic        sfr_rd,                // Register read strobe.
   input  wire logic [7:0]  sfr_wdata,             // Register write data.
   output logic [7:0]       sfr_rdata,             // Register read data.
   input  wire logic [RAM_AW-1:0] ram_addr,        // Scratchpad address.
   input  wire logic        ram_we,                // Scratchpad write strobe.
   input  wire logic [7:0]  ram_wdata,             // Scratchpad write data.
   output logic [7:0]       ram_rdata,             // Scratchpad read data.
   output logic             can_base_addr_select   // Base-address select level.
);
   localparam logic [1:0] MC_LAST   = 2'(`CCT_MC_CLKS - 1);
   localparam logic [3:0] SLOW_LAST = 4'(`CCT_TMR_SLOW_CLKS - 1);
   localparam logic [3:0] FAST_LAST = 4'(`CCT_TMR_FAST_CLKS - 1);

   logic [3:0]  presc;
   logic        fast_q;
   logic [2:0]  mc_left;
   cct_instr_e  cur_class;
   cct_exec_e   state;
   logic [7:0]  port5_control;
   logic [1:0]  can_bit_prescale;
   logic [7:0]  ext_irq_enable_reg;
   logic [7:0]  ext_irq_priority_reg;
   logic [7:0]  mem [RAM_DEPTH];
   logic        mc_end;
   logic        rate_chg;

   // Machine cycles needed by each class.
   function automatic logic [2:0] cycles_of(input cct_instr_e c);
      case (c)
         cct_i_two:   cycles_of = 3'(`CCT_CYC_TWO);
         cct_i_xrd:   cycles_of = 3'(`CCT_CYC_XRD);
         cct_i_movdd: cycles_of = 3'(`CCT_CYC_MOVDD);
         cct_i_incdp: cycles_of = 3'(`CCT_CYC_INCDP);
         cct_i_long4: cycles_of = 3'(`CCT_CYC_LONG4);
         cct_i_long5: cycles_of = 3'(`CCT_CYC_LONG5);
         default:     cycles_of = 3'(`CCT_CYC_ONE);
      endcase
   endfunction

   // Addresses held by the legacy controller; new registers must avoid them.
   function automatic logic is_legacy(input logic [7:0] a);
      is_legacy = (a inside {8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h89,
                             8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h90, 8'h98, 8'h99,
                             8'ha0, 8'ha8, 8'hb0, 8'hb8, 8'hc8, 8'hc9, 8'hca,
                             8'hcb, 8'hcc, 8'hcd, 8'hd0, 8'he0, 8'hf0});
   endfunction

   assign mc_end   = clk_en && (mc_phase == MC_LAST);
   assign rate_chg = clk_en && (fast_timer_sel != fast_q);

   // Divide-by-four machine-cycle phase; ALE marks the first clock of each cycle.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mc_phase <= 2'h0;
         ale      <= 1'b1;
      end else if (clk_en) begin
         mc_phase <= (mc_phase == MC_LAST) ? 2'h0 : mc_phase + 2'h1;
         ale      <= (mc_phase == MC_LAST);
      end
   end

   // Timer prescaler; a rate change restarts it so no short tick slips out.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         presc      <= 4'h0;
         fast_q     <= 1'b0;
         timer_tick <= 1'b0;
      end else if (clk_en) begin
         fast_q <= fast_timer_sel;
         if (rate_chg) begin
            presc      <= 4'h0;
            timer_tick <= 1'b0;
         end else if (presc == (fast_q ? FAST_LAST : SLOW_LAST)) begin
            presc      <= 4'h0;
            timer_tick <= 1'b1;
         end else begin
            presc      <= presc + 4'h1;
            timer_tick <= 1'b0;
         end
      end
   end

   // Requests are taken only on the last clock of a machine cycle.
   assign instr_accept = instr_start && mc_end && (!instr_busy || instr_done);
   assign instr_busy   = (state == cct_run);
   // Timing never alters status effects; decode keeps them standard.
   assign instr_done   = instr_busy && mc_end && (mc_left == 3'h0);

   // Execution sequencer counting whole machine cycles.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state     <= cct_idle;
         mc_left   <= 3'h0;
         cur_class <= cct_i_one;
      end else if (clk_en) begin
         case (state)
            cct_idle: begin
               if (instr_accept) begin
                  state     <= cct_run;
                  mc_left   <= cycles_of(instr_class) - 3'h1;
                  cur_class <= instr_class;
               end
            end
            cct_run: begin
               if (instr_accept) begin
                  mc_left   <= cycles_of(instr_class) - 3'h1;
                  cur_class <= instr_class;
               end else if (instr_done) begin
                  state <= cct_idle;
               end else if (mc_end) begin
                  mc_left <= mc_left - 3'h1;
               end
            end
            default: state <= cct_idle;
         endcase
      end
   end

   // Register writes; of the bits at 8'ha7 only the two prescale bits keep storage.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         port5_control        <= `CCT_RST_REG;
         can_bit_prescale     <= 2'h0;
         ext_irq_enable_reg   <= `CCT_RST_REG;
         ext_irq_priority_reg <= `CCT_RST_REG;
      end else if (clk_en && sfr_wr) begin
         if (sfr_addr == `CCT_ADR_P5CTL) begin
            port5_control <= sfr_wdata;
         end else if (sfr_addr == `CCT_ADR_CANOP) begin
            can_bit_prescale <= {sfr_wdata[`CCT_B_PRE7], sfr_wdata[`CCT_B_PRE6]};
         end else if (sfr_addr == `CCT_ADR_XIEN) begin
            ext_irq_enable_reg <= sfr_wdata;
         end else if (sfr_addr == `CCT_ADR_XIPR) begin
            ext_irq_priority_reg <= sfr_wdata;
         end
      end
   end

   // Registered read mux; unused CAN bits and CAN-only registers read as ones.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sfr_rdata <= `CCT_UNMAPPED;
      end else if (clk_en && sfr_rd) begin
         if (sfr_addr == `CCT_ADR_P5CTL) begin
            sfr_rdata <= port5_control;
         end else if (sfr_addr == `CCT_ADR_CANOP) begin
            sfr_rdata <= `CCT_ONES;
            sfr_rdata[`CCT_B_PRE6] <= can_bit_prescale[0];
            sfr_rdata[`CCT_B_PRE7] <= can_bit_prescale[1];
         end else if (sfr_addr == `CCT_ADR_XIEN) begin
            sfr_rdata <= ext_irq_enable_reg;
         end else if (sfr_addr == `CCT_ADR_XIPR) begin
            sfr_rdata <= ext_irq_priority_reg;
         end else if (sfr_addr >= `CCT_ADR_CAN_LO && sfr_addr <= `CCT_ADR_CAN_HI) begin
            sfr_rdata <= `CCT_ONES;
         end else begin
            sfr_rdata <= `CCT_UNMAPPED;
         end
      end
   end

   // Only the base-address select bit drives logic outside this block.
   assign can_base_addr_select = port5_control[`CCT_B_BASE];

   // Scratchpad storage; contents are data, so reset leaves them alone.
   always_ff @(posedge clock) begin
      if (clk_en) begin
         if (ram_we) begin
            mem[ram_addr] <= ram_wdata;
         end
         ram_rdata <= mem[ram_addr];
      end
   end

   // Helper counters watched only by the checks below.
   logic [3:0] tick_gap;
   logic [4:0] run_clks;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         // Reset restarts the prescaler like a tick one edge earlier would.
         tick_gap <= 4'hf;
         run_clks <= 5'h0;
      end else if (clk_en) begin
         // A rate change restarts the prescaler too, so it must win over a tick.
         tick_gap <= rate_chg ? 4'hf : (timer_tick ? 4'h0 : tick_gap + 4'h1);
         run_clks <= (instr_accept || !instr_busy) ? 5'h0 : run_clks + 5'h1;
      end
   end

   property p_mc_len;
      @(posedge clock) disable iff (!resetn)
      (clk_en && mc_phase == 2'h3) |=> (mc_phase == 2'h0);
   endproperty
   a_mc_len: assert property (p_mc_len) else $error("Machine cycle not four clocks.");

   property p_ale_once;
      @(posedge clock) disable iff (!resetn)
      ale == (mc_phase == 2'h0);
   endproperty
   a_ale_once: assert property (p_ale_once) else $error("ALE not one per cycle.");

   property p_tick_slow;
      @(posedge clock) disable iff (!resetn)
      (clk_en && timer_tick && !fast_q && !rate_chg) |-> (tick_gap == 4'd11);
   endproperty
   a_tick_slow: assert property (p_tick_slow) else $error("Default tick not 12 clocks.");

   property p_tick_fast;
      @(posedge clock) disable iff (!resetn)
      (clk_en && timer_tick && fast_q && !rate_chg) |-> (tick_gap == 4'd3);
   endproperty
   a_tick_fast: assert property (p_tick_fast) else $error("Fast tick not 4 clocks.");

   property p_xrd_len;
      @(posedge clock) disable iff (!resetn)
      (instr_done && cur_class == cct_i_xrd) |-> (run_clks == 5'd7);
   endproperty
   a_xrd_len: assert property (p_xrd_len) else $error("Data read not 8 clocks.");

   property p_movdd_len;
      @(posedge clock) disable iff (!resetn)
      (instr_done && cur_class == cct_i_movdd) |-> (run_clks == 5'd11);
   endproperty
   a_movdd_len: assert property (p_movdd_len) else $error("Move not 12 clocks.");

   property p_incdp_len;
      @(posedge clock) disable iff (!resetn)
      (instr_done && cur_class == cct_i_incdp) |-> (run_clks == 5'd3);
   endproperty
   a_incdp_len: assert property (p_incdp_len) else $error("Increment not one cycle.");

   property p_long5;
      @(posedge clock) disable iff (!resetn)
      (instr_accept && instr_class == cct_i_long5) |-> ##20 instr_done;
   endproperty
   a_long5: assert property (p_long5) else $error("Five-cycle instruction late.");

   property p_new_addr;
      @(posedge clock) disable iff (!resetn)
      !is_legacy(`CCT_ADR_P5CTL) && !is_legacy(`CCT_ADR_CANOP)
         && !is_legacy(`CCT_ADR_XIEN) && !is_legacy(`CCT_ADR_XIPR);
   endproperty
   a_new_addr: assert property (p_new_addr) else $error("New register on legacy address.");

   property p_can_ones;
      @(posedge clock) disable iff (!resetn)
      (clk_en && sfr_rd && sfr_addr >= 8'ha3 && sfr_addr <= 8'ha6) |=> (sfr_rdata == 8'hff);
   endproperty
   a_can_ones: assert property (p_can_ones) else $error("CAN register not all ones.");

   property p_pre_store;
      @(posedge clock) disable iff (!resetn)
      (clk_en && sfr_wr && sfr_addr == 8'ha7) |=> (can_bit_prescale == $past(sfr_wdata[4:3]));
   endproperty
   a_pre_store: assert property (p_pre_store) else $error("Prescale bits not stored.");

   property p_base_sel;
      @(posedge clock) disable iff (!resetn)
      (clk_en && sfr_wr && sfr_addr == 8'ha2) |=> (can_base_addr_select == $past(sfr_wdata[6]));
   endproperty
   a_base_sel: assert property (p_base_sel) else $error("Base select not applied.");

   c_movdd: cover property (@(posedge clock) instr_done && cur_class == cct_i_movdd);
   c_fast:  cover property (@(posedge clock) timer_tick && fast_q);
   c_b2b:   cover property (@(posedge clock) instr_done && instr_accept);
endmodule
`default_nettype wire

// ===== bench/cct_req_model.sv
// Instruction issuer that sits on the far side of the core's request port.
`default_nettype none
module cct_req_model
   import cct_pkg::*;
(
   input  wire logic       clock,         // Oscillator clock.
   input  wire logic       go,            // Bench wants a request raised.
   input  wire cct_instr_e cls,           // Class for the next request.
   input  wire logic       instr_accept,  // Core took the request.
   output var  logic       instr_start,   // Request to the core.
   output var  cct_instr_e instr_class    // Class held with the request.
);
   timeunit 1ns;
   timeprecision 100ps;
   logic taken;

   // The accept is sampled mid-cycle, where it has settled.
   always @(negedge clock) begin
      taken = instr_start && instr_accept;
   end

   // A raised request and its class hold until the edge that takes it.
   // Between requests the class lines invert every clock, so the stale class comes back on every other clock.
   initial begin
      instr_start = 1'b0;
      instr_class = cct_i_one;
   end
   always @(posedge clock) begin
      #2;
      if (!instr_start || taken) begin
         instr_start = go;
         instr_class = go ? cls : cct_instr_e'(~instr_class);
      end
   end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the core cycle timing and compatibility registers.
`default_nettype none
module testbench
   import cct_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0, resetn = 1'b0, clk_en = 1'b1, fast_timer_sel = 1'b0;
   logic go = 1'b0, instr_start, instr_accept, instr_busy, instr_done, ale, timer_tick;
   cct_instr_e cls = cct_i_one, instr_class;
   logic [1:0] mc_phase;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
   logic sfr_wr = 1'b0, sfr_rd = 1'b0, ram_we = 1'b0, can_base_addr_select, base_exp;
   logic [7:0] ram_addr = 8'h00, ram_wdata = 8'h00, ram_rdata;
   int n_errors = 0, n_checks = 0, n;
   cct_instr_e cls_t [7] = '{cct_i_one, cct_i_two, cct_i_xrd, cct_i_movdd,
                             cct_i_incdp, cct_i_long4, cct_i_long5};
   int cyc_t [7] = '{1, 2, 2, 3, 1, 4, 5};
   logic [7:0] reg_t [9][3] = '{'{8'ha2, 8'hff, 8'hff}, '{8'ha2, 8'h40, 8'h40},
      '{8'ha3, 8'h00, 8'hff}, '{8'ha6, 8'h00, 8'hff}, '{8'ha7, 8'h00, 8'he7},
      '{8'ha7, 8'hff, 8'hff}, '{8'he8, 8'h40, 8'h40}, '{8'hf8, 8'hbf, 8'hbf},
      '{8'h10, 8'h5a, 8'h00}};

   // Oscillator at 100 MHz.
   always #5 clock = ~clock;

   cct_core_timing dut_u (.clock(clock), .resetn(resetn), .clk_en(clk_en),
      .fast_timer_sel(fast_timer_sel), .instr_start(instr_start),
      .instr_class(instr_class), .instr_accept(instr_accept), .instr_busy(instr_busy),
      .instr_done(instr_done), .mc_phase(mc_phase), .ale(ale), .timer_tick(timer_tick),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .ram_addr(ram_addr), .ram_we(ram_we),
      .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
      .can_base_addr_select(can_base_addr_select));

   cct_req_model req_u (.clock(clock), .go(go), .cls(cls), .instr_accept(instr_accept),
      .instr_start(instr_start), .instr_class(instr_class));

   // Compares one value and counts the outcome.
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Prints the verdict and ends the run.
   task automatic results();
      if (n_errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Waits mid-cycle for a signal, bounded so a dead output cannot hang.
   task automatic wait_hi(ref logic s, input string nm);
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (s !== 1'b1 && n < 64);
      if (s !== 1'b1) chk(nm, 8'h00, 8'h01);
   endtask

   // Counts clocks from one mid-cycle sample of a strobe to its next one.
   task automatic gap(ref logic s, input string nm, input int exp);
      wait_hi(s, nm);
      wait_hi(s, nm);
      chk(nm, 8'(n), 8'(exp));
   endtask

   // Register write then read back one edge later.
   task automatic sfr_cycle(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock) #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge clock) #1;
      sfr_wr = 1'b0;
      sfr_rd = 1'b1;
      @(posedge clock) #1;
      sfr_rd = 1'b0;
   endtask

   // Runs one instruction and returns the clocks from accept to done in n.
   task automatic run_instr(input cct_instr_e c);
      @(posedge clock) #1;
      cls = c;
      go = 1'b1;
      wait_hi(instr_accept, "accept");
      @(posedge clock) #1;
      go = 1'b0;
      n = 0;
      while (instr_done !== 1'b1 && n < 64) begin
         @(negedge clock);
         n++;
      end
   endtask

   // Watchdog sized well beyond the few hundred clocks the tests need.
   initial begin
      #200000;
      n_errors++;
      results();
   end

   initial begin
      repeat (3) @(posedge clock);
      chk("reset phase", 8'(mc_phase), 8'h00);
      chk("reset ale", 8'(ale), 8'h01);
      chk("reset tick", 8'(timer_tick), 8'h00);
      chk("reset busy", 8'(instr_busy), 8'h00);
      chk("reset base", 8'(can_base_addr_select), 8'h00);
      #1 resetn = 1'b1;
      // Phase walks 0,1,2,3 from release with the latch pulse only on phase 0.
      for (int k = 0; k < 8; k++) begin
         @(negedge clock);
         chk("phase", 8'(mc_phase), 8'(k % 4));
         chk("ale", 8'(ale), 8'((k % 4) == 0));
      end
      gap(timer_tick, "slow tick gap", 12);
      @(posedge clock) #1 fast_timer_sel = 1'b1;
      gap(timer_tick, "fast tick gap", 4);
      gap(ale, "ale gap", 4);
      // Every timing class, accept to done.
      for (int i = 0; i < 7; i++) begin
         run_instr(cls_t[i]);
         chk("instr clocks", 8'(n), 8'(4 * cyc_t[i]));
      end
      // Register table, including the read-as-ones window and an unmapped place.
      base_exp = 1'b0;
      for (int i = 0; i < 9; i++) begin
         sfr_cycle(reg_t[i][0], reg_t[i][1]);
         if (reg_t[i][0] == 8'ha2) base_exp = reg_t[i][1][6];
         chk("sfr read", sfr_rdata, reg_t[i][2]);
         chk("base select", 8'(can_base_addr_select), 8'(base_exp));
      end
      // Back-to-back: the second request is taken in the done cycle.
      @(posedge clock) #1;
      cls = cct_i_movdd;
      go = 1'b1;
      wait_hi(instr_accept, "accept");
      wait_hi(instr_done, "done");
      chk("b2b accept", 8'(instr_accept), 8'h01);
      @(posedge clock) #1 go = 1'b0;
      wait_hi(instr_done, "b2b done");
      chk("b2b done", 8'(n), 8'h0c);
      // Scratchpad ends.
      for (int i = 0; i < 2; i++) begin
         @(posedge clock) #1;
         ram_addr = i ? 8'hff : 8'h00;
         ram_wdata = i ? 8'h3c : 8'hc3;
         ram_we = 1'b1;
         @(posedge clock) #1 ram_we = 1'b0;
         @(posedge clock) #1;
         chk("ram", ram_rdata, i ? 8'h3c : 8'hc3);
      end
      // A frozen clock enable holds the phase.
      @(posedge clock) #1 clk_en = 1'b0;
      n = int'(mc_phase);
      repeat (5) @(posedge clock);
      #1 chk("frozen phase", 8'(mc_phase), 8'(n));
      clk_en = 1'b1;
      // Second reset in mid-run clears the counters.
      resetn = 1'b0;
      #2 chk("rereset phase", 8'(mc_phase), 8'h00);
      chk("rereset sfr", sfr_rdata, 8'h00);
      @(posedge clock) #1 resetn = 1'b1;
      // The first enabled edge after release moves the phase to one.
      @(negedge clock);
      chk("rerelease phase", 8'(mc_phase), 8'h00);
      @(negedge clock);
      chk("rerelease phase", 8'(mc_phase), 8'h01);
      results();
   end
endmodule
`default_nettype wire
